// *** design/serial_port_config_cfg.svh ***
// offsets, field positions, reset values and counts of the serial port configuration
`ifndef SERIAL_PORT_CONFIG_CFG_SVH
`define SERIAL_PORT_CONFIG_CFG_SVH

`define CFG_A_ADDR 15'h0000
`define CFG_B_ADDR 15'h0001
`define APPLY_ADDR 15'h000F

`define A_SOFT_RESET 7
`define A_LSB_FIRST 6
`define A_ASCEND 5
`define A_OUT_EN 4
`define A_MIRROR(b) (7 - (b))

`define B_READ_BUF 5
`define B_LOGIC_RESET 2
`define APPLY_BIT 0

`define CFG_A_RESET 8'h00
`define CFG_B_RESET 8'h00

`define INSTR_LAST 4'hF
`define DATA_LAST 4'h7

`endif

// *** design/serial_port_config_pkg.sv ***
// types shared by the serial port configuration block
package serial_port_config_pkg;

	typedef enum logic [1:0] {
		PH_INSTR = 2'h1,
		PH_DATA = 2'h2
	} phase_e;

	typedef struct packed {
		logic lsb_first;
		logic addr_ascend;
		logic output_pin_enable;
		logic read_buffered;
	} settings_s;

endpackage

// *** design/serial_port_config_regs.sv ***
// serial port configuration registers with their own spi slave on the link clock
`timescale 1ns/10ps
`include "serial_port_config_cfg.svh"
// Function
// - bit 7 write: full reset plus eeprom load
// - bit 6 set: shift least significant first
// - bit 5 set increments address, else decrements
// - bit 4 set: four-wire, sdo pin driven
// - spi settings ignored in i2c mode
// - bits 3..0 mirror 4..7, ored together
// - both config registers never saved to eeprom
// - config b bit 5 selects buffered readback
// - config b bit 2: reset, keep registers
// - apply bit copies buffers, then self-clears
module serial_port_config_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	input wire logic i2c_mode,
	input wire logic eeprom_enable,
	input wire logic [14:0] save_addr,
	output logic sdio_out,
	output logic sdio_oe_n,
	output logic sdo,
	output logic sdo_oe_n,
	output logic soft_reset,
	output logic eeprom_load,
	output logic logic_reset,
	output logic io_apply,
	output logic save_allowed,
	output serial_port_config_pkg::settings_s settings
);

	// ----------------------------------------
	// frame engine (sclk rising, cleared by cs_n)
	// ----------------------------------------
	serial_port_config_pkg::phase_e phase, next_phase;
	logic [3:0] cnt, next_cnt;
	logic [15:0] sh, next_sh;
	logic [14:0] addr, next_addr;
	logic rw, next_rw;
	logic [7:0] rd_byte, next_rd_byte;
	logic wr_en;
	logic [7:0] wr_data;

	// register state (sclk rising, reset by rst only)
	logic [7:0] cfg_a, next_cfg_a;
	logic cfg_b_buf, next_cfg_b_buf;
	logic [2:0] req, next_req;
	logic [2:0] ack_s1, ack_s2;
	logic i2c_s1, i2c_s2;
	serial_port_config_pkg::settings_s eff, next_eff;
	logic [2:0] pend;

	// clk domain
	logic [2:0] req_s1, req_s2, req_prev;
	serial_port_config_pkg::settings_s set_s1, set_s2, next_settings;
	logic next_soft, next_logic, next_apply, next_save;

	// output drivers (sclk falling)
	logic next_sdio_out, next_sdio_oe_n, next_sdo_oe_n;

	assign pend = req ^ ack_s2;

	function automatic logic [7:0] read_mux(input logic [14:0] a);
		case (a)
			`CFG_A_ADDR: read_mux = {pend[0], cfg_a[6:1], pend[0]};
			`CFG_B_ADDR: read_mux = {2'h0, cfg_b_buf, 2'h0, pend[1], 2'h0};
			`APPLY_ADDR: read_mux = {7'h00, pend[2]};
			default: read_mux = 8'h00;
		endcase
	endfunction

	always_comb begin
		next_phase = phase;
		next_cnt = cnt;
		next_addr = addr;
		next_rw = rw;
		next_rd_byte = rd_byte;
		wr_en = 1'b0;
		wr_data = 8'h00;
		// right shift when lsb first so words land in the same order
		next_sh = eff.lsb_first ? {sdio_in, sh[15:1]} : {sh[14:0], sdio_in};
		case (phase)
			serial_port_config_pkg::PH_INSTR: begin
				if (cnt == `INSTR_LAST) begin
					next_rw = next_sh[15];
					next_addr = next_sh[14:0];
					next_rd_byte = read_mux(next_sh[14:0]);
					next_phase = serial_port_config_pkg::PH_DATA;
					next_cnt = 4'h0;
				end else begin
					next_cnt = cnt + 4'h1;
				end
			end
			serial_port_config_pkg::PH_DATA: begin
				if (cnt == `DATA_LAST) begin
					wr_en = ~rw;
					wr_data = eff.lsb_first ? next_sh[15:8] : next_sh[7:0];
					next_addr = eff.addr_ascend ? addr + 15'h0001 : addr - 15'h0001;
					next_rd_byte = read_mux(next_addr);
					next_cnt = 4'h0;
				end else begin
					next_cnt = cnt + 4'h1;
				end
			end
			default: begin
				next_phase = serial_port_config_pkg::PH_INSTR;
				next_cnt = 4'h0;
			end
		endcase
	end

	always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
		if (rst || cs_n) begin
			phase <= serial_port_config_pkg::PH_INSTR;
			cnt <= 4'h0;
			sh <= 16'h0000;
			addr <= 15'h0000;
			rw <= 1'b0;
			rd_byte <= 8'h00;
		end else begin
			phase <= next_phase;
			cnt <= next_cnt;
			sh <= next_sh;
			addr <= next_addr;
			rw <= next_rw;
			rd_byte <= next_rd_byte;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_comb begin
		next_cfg_a = cfg_a;
		next_cfg_b_buf = cfg_b_buf;
		next_req = req;
		if (wr_en) begin
			case (addr)
				`CFG_A_ADDR: begin
					if (wr_data[`A_SOFT_RESET] | wr_data[`A_MIRROR(`A_SOFT_RESET)]) begin
						// full reset returns both registers to defaults
						next_cfg_a = `CFG_A_RESET;
						next_cfg_b_buf = 1'(`CFG_B_RESET >> `B_READ_BUF);
						if (!pend[0]) begin
							next_req[0] = ~req[0];
						end
					end else begin
						next_cfg_a = {1'b0, wr_data[6:1], 1'b0};
					end
				end
				`CFG_B_ADDR: begin
					next_cfg_b_buf = wr_data[`B_READ_BUF];
					if (wr_data[`B_LOGIC_RESET] && !pend[1]) begin
						next_req[1] = ~req[1];
					end
				end
				`APPLY_ADDR: begin
					if (wr_data[`APPLY_BIT] && !pend[2]) begin
						next_req[2] = ~req[2];
					end
				end
				default: begin
					next_req = req;
				end
			endcase
		end
		// each config a setting is the or of its bit and its mirror; zero in i2c mode
		// taken from the next values: the next frame must already shift in the new order
		next_eff.lsb_first = (next_cfg_a[`A_LSB_FIRST]
			| next_cfg_a[`A_MIRROR(`A_LSB_FIRST)]) & ~i2c_s2;
		next_eff.addr_ascend = (next_cfg_a[`A_ASCEND]
			| next_cfg_a[`A_MIRROR(`A_ASCEND)]) & ~i2c_s2;
		next_eff.output_pin_enable = (next_cfg_a[`A_OUT_EN]
			| next_cfg_a[`A_MIRROR(`A_OUT_EN)]) & ~i2c_s2;
		next_eff.read_buffered = next_cfg_b_buf;
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			cfg_a <= `CFG_A_RESET;
			cfg_b_buf <= 1'b0;
			req <= 3'h0;
			ack_s1 <= 3'h0;
			ack_s2 <= 3'h0;
			i2c_s1 <= 1'b0;
			i2c_s2 <= 1'b0;
			eff <= '0;
		end else begin
			cfg_a <= next_cfg_a;
			cfg_b_buf <= next_cfg_b_buf;
			req <= next_req;
			ack_s1 <= req_prev;
			ack_s2 <= ack_s1;
			i2c_s1 <= i2c_mode;
			i2c_s2 <= i2c_s1;
			eff <= next_eff;
		end
	end

	// ----------------------------------------
	// readback drivers
	// ----------------------------------------
	always_comb begin
		next_sdio_out = eff.lsb_first ? rd_byte[cnt[2:0]] : rd_byte[3'h7 - cnt[2:0]];
		next_sdio_oe_n = ~((phase == serial_port_config_pkg::PH_DATA) & rw & ~eff.output_pin_enable);
		next_sdo_oe_n = ~((phase == serial_port_config_pkg::PH_DATA) & rw & eff.output_pin_enable);
	end

	// data changes on the falling edge so the host samples it stable
	always_ff @(negedge sclk or posedge rst or posedge cs_n) begin
		if (rst || cs_n) begin
			sdio_out <= 1'b0;
			sdo <= 1'b0;
			sdio_oe_n <= 1'b1;
			sdo_oe_n <= 1'b1;
		end else begin
			sdio_out <= next_sdio_out;
			sdo <= next_sdio_out;
			sdio_oe_n <= next_sdio_oe_n;
			sdo_oe_n <= next_sdo_oe_n;
		end
	end

	// ----------------------------------------
	// core clock side
	// ----------------------------------------
	always_comb begin
		next_soft = req_s2[0] ^ req_prev[0];
		next_logic = req_s2[1] ^ req_prev[1];
		next_apply = req_s2[2] ^ req_prev[2];
		// settings word crosses unhandshaked; take it only once two samples agree
		next_settings = (set_s1 == set_s2) ? set_s2 : settings;
		// config registers are left out of any eeprom save
		next_save = (save_addr != `CFG_A_ADDR) && (save_addr != `CFG_B_ADDR);
	end

	// req_prev is the acknowledge toggle; pending clears once the pulse has gone out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_s1 <= 3'h0;
			req_s2 <= 3'h0;
			req_prev <= 3'h0;
			set_s1 <= '0;
			set_s2 <= '0;
			settings <= '0;
			soft_reset <= 1'b0;
			eeprom_load <= 1'b0;
			logic_reset <= 1'b0;
			io_apply <= 1'b0;
			save_allowed <= 1'b0;
		end else begin
			req_s1 <= req;
			req_s2 <= req_s1;
			req_prev <= req_s2;
			set_s1 <= eff;
			set_s2 <= set_s1;
			settings <= next_settings;
			soft_reset <= next_soft;
			eeprom_load <= next_soft & eeprom_enable;
			logic_reset <= next_logic;
			io_apply <= next_apply;
			save_allowed <= next_save;
		end
	end

endmodule // serial_port_config_regs

// *** test/serial_port_config_monitor.sv ***
// concurrent checks on the serial port configuration outputs
`timescale 1ns/10ps
module serial_port_config_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic eeprom_enable,
	input wire logic [14:0] save_addr,
	input wire logic sdio_oe_n,
	input wire logic sdo_oe_n,
	input wire logic soft_reset,
	input wire logic eeprom_load,
	input wire logic logic_reset,
	input wire logic io_apply,
	input wire logic save_allowed,
	input wire serial_port_config_pkg::settings_s settings
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	load_gate_a: assert property (eeprom_load |-> soft_reset && $past(eeprom_enable))
		else $error("eeprom load without reset or enable");
	sreset_once_a: assert property (soft_reset |=> !soft_reset)
		else $error("soft reset longer than one cycle");
	lreset_once_a: assert property (logic_reset |=> !logic_reset)
		else $error("logic reset longer than one cycle");
	apply_once_a: assert property (io_apply |=> !io_apply)
		else $error("apply longer than one cycle");
	save_gate_a: assert property (save_allowed == ($past(save_addr) > 15'h0001))
		else $error("save permission wrong");
	oe_excl_a: assert property (!(!sdio_oe_n && !sdo_oe_n))
		else $error("both data outputs enabled");
	idle_oe_a: assert property (cs_n |-> sdio_oe_n && sdo_oe_n)
		else $error("data output enabled while deselected");
	clear_cfg_a: assert property (soft_reset |-> ##[0:16] settings == 4'h0)
		else $error("settings kept after soft reset");
	sr_c: cover property (soft_reset && eeprom_load);
	lr_c: cover property (logic_reset);
	ap_c: cover property (io_apply);
endmodule // serial_port_config_monitor

// *** test/spi_host_model.sv ***
// host side serial port model; link clock stands low outside frames
`timescale 1ns/10ps
module spi_host_model (
	output logic sclk,
	output logic cs_n,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_n,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	logic lsb = 1'b0;
	logic fw = 1'b0;
	logic hb = 1'b0;
	// shared wire: device wins while enabled, else host pattern
	assign sdio_in = sdio_oe_n ? hb : sdio_out;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end
	// n bytes; n of -1 gives a partial frame that only clocks the link
	task automatic xfer(input logic rw, input logic [14:0] a, input logic [15:0] wd,
		input int n, output logic [15:0] rd);
		logic [15:0] ins;
		int i;
		ins = {rw, a};
		rd = 16'h0000;
		cs_n = 1'b0;
		for (int k = 0; k < 16 + 8 * n; k++) begin
			i = (k - 16) / 8 * 8 + (lsb ? k % 8 : 7 - k % 8);
			if (k < 16)
				hb = lsb ? ins[k] : ins[15 - k];
			else if (!rw)
				hb = wd[i];
			else
				hb = ~hb;
			#7.5 sclk = 1'b1;
			if (rw && k > 15)
				rd[i] = fw ? (sdo_oe_n ? 1'bx : sdo) : (sdio_oe_n ? 1'bx : sdio_out);
			#7.5 sclk = 1'b0;
		end
		#7.5 cs_n = 1'b1;
		hb = ~hb;
		// deselect gap, so a following frame never lowers cs_n in the same step
		#15;
	endtask
endmodule // spi_host_model

// *** test/tb_top.sv ***
// self-checking bench of the serial port configuration registers
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic i2c_mode = 1'b0;
	logic eeprom_enable = 1'b0;
	logic [14:0] save_addr = 15'h0000;
	logic sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, sdo, sdo_oe_n;
	logic soft_reset, eeprom_load, logic_reset, io_apply, save_allowed;
	serial_port_config_pkg::settings_s settings;
	logic [15:0] rd;
	int miscompares = 0;
	int n_checks = 0;
	wire [2:0] pl = {io_apply, logic_reset, soft_reset};
	always #50 clk = ~clk;
	serial_port_config_regs u_dut (.clk, .rst, .sclk, .cs_n, .sdio_in, .i2c_mode,
		.eeprom_enable, .save_addr, .sdio_out, .sdio_oe_n, .sdo, .sdo_oe_n, .soft_reset,
		.eeprom_load, .logic_reset, .io_apply, .save_allowed, .settings);
	spi_host_model u_host (.sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe_n, .sdo, .sdo_oe_n);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [15:0] d, input int n = 1);
		u_host.xfer(1'b0, a, d, n, rd);
	endtask
	task automatic rdc(input logic [14:0] a, input logic [15:0] e, input int n = 1);
		u_host.xfer(1'b1, a, 16'h0000, n, rd);
		chk("read", e, rd);
	endtask
	// link settles only while clocked, so a partial frame follows each change
	task automatic fl;
		u_host.xfer(1'b1, 15'h0000, 16'h0000, -1, rd);
		repeat (10) @(posedge clk);
		#1;
	endtask
	task automatic cs(input logic [3:0] e);
		fl;
		chk("settings", {12'h000, e}, {12'h000, settings});
	endtask
	task automatic pulse(input int i, input logic el);
		int t;
		t = 0;
		while (pl[i] !== 1'b1 && t < 40) begin
			@(posedge clk);
			#1;
			t++;
		end
		chk("pulse", 16'h0001, {15'h0000, pl[i]});
		chk("load", {15'h0000, el}, {15'h0000, eeprom_load});
		fl;
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		rdc(15'h0000, 16'h0000);
		rdc(15'h0001, 16'h0000);
		wr(15'h0000, 16'h0004);
		cs(4'h4);
		wr(15'h0000, 16'h0008);
		cs(4'h2);
		u_host.fw = 1'b1;
		rdc(15'h0000, 16'h0008);
		wr(15'h0000, 16'h0010);
		cs(4'h2);
		rdc(15'h0000, 16'h0010);
		u_host.fw = 1'b0;
		wr(15'h0000, 16'h0042);
		cs(4'h8);
		u_host.lsb = 1'b1;
		rdc(15'h0000, 16'h0042);
		wr(15'h0000, 16'h0000);
		u_host.lsb = 1'b0;
		wr(15'h0001, 16'h00FB, 2);
		cs(4'h1);
		rdc(15'h0001, 16'h0020, 2);
		wr(15'h0000, 16'h0024);
		fl;
		wr(15'h0000, 16'h0024, 2);
		cs(4'h4);
		rdc(15'h0000, 16'h0024, 2);
		wr(15'h0001, 16'h0024);
		pulse(1, 1'b0);
		rdc(15'h0001, 16'h0020);
		wr(15'h000F, 16'h0001);
		pulse(2, 1'b0);
		rdc(15'h000F, 16'h0000);
		wr(15'h0002, 16'h00FF);
		rdc(15'h0002, 16'h0000);
		i2c_mode = 1'b1;
		fl;
		chk("i2c", 16'h0000, {13'h0000, settings[3:1]});
		i2c_mode = 1'b0;
		eeprom_enable = 1'b1;
		wr(15'h0000, 16'h0001);
		pulse(0, 1'b1);
		rdc(15'h0000, 16'h0000);
		rdc(15'h0001, 16'h0000);
		@(posedge clk);
		#1 eeprom_enable = 1'b0;
		wr(15'h0000, 16'h0080);
		pulse(0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			save_addr = 15'(i);
			repeat (2) @(posedge clk);
			#1;
			chk("save", {15'h0000, i > 1}, {15'h0000, save_allowed});
		end
		complete_run;
	end
endmodule // tb_top
bind serial_port_config_regs serial_port_config_monitor u_mon (.clk, .rst, .cs_n,
	.eeprom_enable, .save_addr, .sdio_oe_n, .sdo_oe_n, .soft_reset, .eeprom_load,
	.logic_reset, .io_apply, .save_allowed, .settings);
